/* File: include/ubp_cfg.svh */
/*
  Address map, field positions, codes and timing counts of the byte port block.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef UBP_CFG_SVH
`define UBP_CFG_SVH
// ==========================================================================
// Register byte addresses.
`define UBP_ADDR_CTRL_A 8'h00
`define UBP_ADDR_CTRL_B 8'h04
`define UBP_ADDR_GEN 8'h08
`define UBP_ADDR_STAT 8'h0c
`define UBP_ADDR_DDR_A 8'h10
`define UBP_ADDR_DDR_B 8'h14
`define UBP_ADDR_DATA_A 8'h18
`define UBP_ADDR_DATA_B 8'h1c
// ==========================================================================
// Control register fields and codes.
`define UBP_SUB_HI 7
`define UBP_SUB_LO 6
`define UBP_AUX_HI 5
`define UBP_AUX_LO 3
`define UBP_AUX_OUT_BIT 5
`define UBP_AUXIE_BIT 2
`define UBP_SVCE_BIT 1
`define UBP_STC_BIT 0
`define UBP_SUB_IN 2'h0
`define UBP_SUB_OUT 2'h1
`define UBP_AUX_NEG 3'h4
`define UBP_AUX_ASR 3'h5
`define UBP_AUX_ILK 3'h6
`define UBP_AUX_PLS 3'h7
`define UBP_CTRL_RST 8'h00
// ==========================================================================
// Timing in clock cycles, pin polarity and bus answers.
`define UBP_HS_DELAY_CYC 2'h2
`define UBP_PULSE_CYC 3'h4
`define UBP_ACT_HIGH 1'b1
`define UBP_RESP_OKAY 2'h0
`define UBP_RESP_DECERR 2'h3
`endif

/* File: include/ubp_pkg.sv */
/*
  Types of the byte port block: per-port state and bus slave state.
  Assumes ubp_cfg.svh is not needed here; widths are fixed.
*/
package ubp_pkg;
  // ========================================================================
  // State of one port.
  typedef struct packed {
    logic [7:0] ctrl;    // Port control register.
    logic [7:0] ddr;     // Direction, one means output.
    logic [7:0] olat;    // Final output latch, drives the pins.
    logic [7:0] iol;     // Initial output latch.
    logic [7:0] fil;     // Final input latch, seen by reads.
    logic [7:0] iil;     // Initial input latch.
    logic [1:0] cnt;     // Bytes held in the double buffer.
    logic [1:0] dly;     // Countdown to the handshake assertion.
    logic [2:0] pw;      // Countdown of the handshake pulse.
    logic aux_on;        // Handshake output asserted.
    logic pres;          // A byte was presented and awaits its ack.
    logic owed;          // A handshake assertion is still owed.
    logic aux_st;        // Second-pin status bit.
    logic strobe_st;     // First-pin status bit.
    logic svc;           // Service request output.
    logic auxirq;        // Second-pin interrupt output.
    logic aux_pin;       // Second-pin output level.
    logic aux_oe;        // Second-pin output enable.
  } ubp_port_t;
  // ========================================================================
  // State of the AXI4-Lite slave.
  typedef struct packed {
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ubp_axil_t;
endpackage

/* File: logic/ubp_edge.sv */
/*
  Asserted-sense conversion and asserted-edge detection for handshake pins.
  Assumes the pins are synchronous to i_clk.
*/
`include "ubp_cfg.svh"
module ubp_edge (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Pin levels.
  input wire logic [3:0] i_pin,
  // Asserted level and asserted edge.
  output logic [3:0] o_asr,
  output logic [3:0] o_edge
);
  // ========================================================================
  // Previous asserted level, one flip-flop per pin.
  logic [3:0] prev_q;
  logic [3:0] prev_d;

  // Convert to the asserted sense so that every edge means the same thing.
  always_comb begin
    o_asr = i_pin ^ {4{~`UBP_ACT_HIGH}};
    o_edge = o_asr & ~prev_q;
    prev_d = o_asr;
  end

  // Reset assumes all pins negated, so a pin held asserted gives one edge.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

/* File: logic/ubp_axil.sv */
/*
  AXI4-Lite slave for the byte port block, one write and one read at a time.
  Assumes the parent answers i_wr_ok, i_rd_ok and i_rd_data combinationally.
*/
`include "ubp_cfg.svh"
module ubp_axil (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Write channels.
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // Read channels.
  input wire logic i_arvalid,
  output logic o_arready,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Register side.
  output logic o_wr_en,
  output logic [7:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  input wire logic i_wr_ok,
  output logic o_rd_en,
  input wire logic i_rd_ok,
  input wire logic [31:0] i_rd_data
);
  // ========================================================================
  // State and next state.
  ubp_pkg::ubp_axil_t q;
  ubp_pkg::ubp_axil_t d;

  // Readies are plain functions of state, so they never drop mid-handshake.
  assign o_awready = !q.aw_full;
  assign o_wready = !q.w_full;
  assign o_arready = !q.rvalid;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign o_wr_addr = q.awaddr;
  assign o_wr_data = q.wdata;
  assign o_wr_strb = q.wstrb;
  assign o_wr_en = q.aw_full && q.w_full && !q.bvalid;
  assign o_rd_en = i_arvalid && !q.rvalid;

  // Take address and data in either order; act once both are held.
  always_comb begin
    d = q;
    if (i_awvalid && !q.aw_full) begin
      d.aw_full = 1'b1;
      d.awaddr = i_awaddr;
    end
    if (i_wvalid && !q.w_full) begin
      d.w_full = 1'b1;
      d.wdata = i_wdata;
      d.wstrb = i_wstrb;
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end
    if (o_wr_en) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = i_wr_ok ? `UBP_RESP_OKAY : `UBP_RESP_DECERR;
    end
    if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end
    if (o_rd_en) begin
      d.rvalid = 1'b1;
      d.rdata = i_rd_data;
      d.rresp = i_rd_ok ? `UBP_RESP_OKAY : `UBP_RESP_DECERR;
    end
  end

  // Register the state.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

/* File: logic/ubp_top.sv */
/*
  Two 8-bit unidirectional byte ports with handshakes: double-buffered input
  in submode 00 and double-buffered output in submode 01, behind AXI4-Lite.
  Assumes all pins are synchronous to i_clk and that the bus master obeys
  AXI4-Lite; port A sits in bits 7:0 of the data pins, port B in 15:8.
*/
`include "ubp_cfg.svh"

module ubp_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // AXI4-Lite write address, data and response.
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read address and data.
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [7:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // Port data pins, port A low byte, port B high byte.
  input wire logic [15:0] i_port_data,
  output logic [15:0] o_port_data,
  output logic [15:0] o_port_data_oe,
  // First handshake pins, index 0 for port A.
  input wire logic [1:0] i_strobe_in,
  // Second handshake pins, two-way.
  input wire logic [1:0] i_handshake_aux,
  output logic [1:0] o_handshake_aux,
  output logic [1:0] o_handshake_aux_oe,
  // Service requests and second-pin interrupts.
  output logic [1:0] o_service_request,
  output logic [1:0] o_aux_irq
);
  // ========================================================================
  // Block state: both ports and the pair enables.
  typedef struct packed {
    ubp_pkg::ubp_port_t [1:0] port; // Per-port state.
    logic [1:0] en;                 // Pair enables, bit 0 for port A.
  } ubp_top_st_t;

  ubp_top_st_t q; // Registered state.
  ubp_top_st_t d; // Next state.

  // Register-side strobes from the bus slave.
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [31:0] rd_data;
  // Handshake pins in the asserted sense.
  logic [3:0] hs_asr;
  logic [3:0] hs_edge;

  // ========================================================================
  // Address decode, used for both reads and writes.
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `UBP_ADDR_CTRL_A) || (a == `UBP_ADDR_CTRL_B) ||
              (a == `UBP_ADDR_GEN) || (a == `UBP_ADDR_STAT) ||
              (a == `UBP_ADDR_DDR_A) || (a == `UBP_ADDR_DDR_B) ||
              (a == `UBP_ADDR_DATA_A) || (a == `UBP_ADDR_DATA_B);
  endfunction

  // Turn an asserted level into the pin level.
  function automatic logic pin_lvl(input logic a);
    pin_lvl = a ^ ~`UBP_ACT_HIGH;
  endfunction

  // Byte seen by a data register read: latched input or pin where the
  // direction bit is zero, the final output latch where it is one.
  function automatic logic [7:0] data_rd(input ubp_pkg::ubp_port_t p, input logic [7:0] pin);
    logic [7:0] src;
    src = (p.ctrl[`UBP_SUB_HI:`UBP_SUB_LO] == `UBP_SUB_IN) ? p.fil : pin;
    data_rd = (src & ~p.ddr) | (p.olat & p.ddr);
  endfunction

  // ========================================================================
  // Bus slave.
  ubp_axil u_axil (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_awvalid(i_axi_awvalid),
    .o_awready(o_axi_awready),
    .i_awaddr(i_axi_awaddr),
    .i_wvalid(i_axi_wvalid),
    .o_wready(o_axi_wready),
    .i_wdata(i_axi_wdata),
    .i_wstrb(i_axi_wstrb),
    .o_bvalid(o_axi_bvalid),
    .i_bready(i_axi_bready),
    .o_bresp(o_axi_bresp),
    .i_arvalid(i_axi_arvalid),
    .o_arready(o_axi_arready),
    .o_rvalid(o_axi_rvalid),
    .i_rready(i_axi_rready),
    .o_rdata(o_axi_rdata),
    .o_rresp(o_axi_rresp),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_ok(addr_ok(wr_addr)),
    .o_rd_en(rd_en),
    .i_rd_ok(addr_ok(i_axi_araddr)),
    .i_rd_data(rd_data)
  );

  // Edge detection: strobes in bits 1:0, auxiliary inputs in bits 3:2.
  ubp_edge u_edge (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pin({i_handshake_aux, i_strobe_in}),
    .o_asr(hs_asr),
    .o_edge(hs_edge)
  );

  // ========================================================================
  // Read multiplexer; unmapped addresses read zero with an error answer.
  always_comb begin
    case (i_axi_araddr)
      `UBP_ADDR_CTRL_A: rd_data = {24'h0, q.port[0].ctrl};
      `UBP_ADDR_CTRL_B: rd_data = {24'h0, q.port[1].ctrl};
      `UBP_ADDR_GEN: rd_data = {30'h0, q.en};
      `UBP_ADDR_STAT: rd_data = {28'h0, q.port[1].aux_st, q.port[1].strobe_st,
                                 q.port[0].aux_st, q.port[0].strobe_st};
      `UBP_ADDR_DDR_A: rd_data = {24'h0, q.port[0].ddr};
      `UBP_ADDR_DDR_B: rd_data = {24'h0, q.port[1].ddr};
      `UBP_ADDR_DATA_A: rd_data = {24'h0, data_rd(q.port[0], i_port_data[7:0])};
      `UBP_ADDR_DATA_B: rd_data = {24'h0, data_rd(q.port[1], i_port_data[15:8])};
      default: rd_data = 32'h0;
    endcase
  end

  // ========================================================================
  // Port engines. After its control and direction writes, each port goes in order: timers, then
  // bus reads, then pin events, then bus writes, so that a write in the same
  // cycle as an acknowledge lands in the latch the acknowledge just freed.
  always_comb begin
    logic [1:0] sub;
    logic [2:0] aux;
    logic hs;
    logic wr_byte;
    logic take;
    logic [7:0] pin_in;
    sub = 2'h0;
    aux = 3'h0;
    hs = 1'b0;
    wr_byte = 1'b0;
    take = 1'b0;
    pin_in = 8'h0;
    d = q;
    // General control: pair enables.
    if (wr_en && wr_strb[0] && wr_addr == `UBP_ADDR_GEN) begin
      d.en = wr_data[1:0];
    end
    for (int p = 0; p < 2; p++) begin
      sub = q.port[p].ctrl[`UBP_SUB_HI:`UBP_SUB_LO];
      aux = q.port[p].ctrl[`UBP_AUX_HI:`UBP_AUX_LO];
      hs = (aux == `UBP_AUX_ILK) || (aux == `UBP_AUX_PLS);
      pin_in = i_port_data[8*p +: 8];
      // Control and direction writes.
      if (wr_en && wr_strb[0] && wr_addr == (p == 0 ? `UBP_ADDR_CTRL_A : `UBP_ADDR_CTRL_B)) begin
        d.port[p].ctrl = wr_data[7:0];
      end
      if (wr_en && wr_strb[0] && wr_addr == (p == 0 ? `UBP_ADDR_DDR_A : `UBP_ADDR_DDR_B)) begin
        d.port[p].ddr = wr_data[7:0];
      end
      wr_byte = wr_en && wr_strb[0] && wr_addr == (p == 0 ? `UBP_ADDR_DATA_A : `UBP_ADDR_DATA_B);
      // Assertion delay: the handshake rises as the count runs out.
      if (q.port[p].dly != 2'h0) begin
        d.port[p].dly = q.port[p].dly - 2'h1;
        if (q.port[p].dly == 2'h1 && hs) begin
          d.port[p].aux_on = 1'b1;
          d.port[p].pres = 1'b1;
          d.port[p].pw = `UBP_PULSE_CYC;
        end
      end
      // Pulse width: a pulsed handshake drops after four cycles.
      if (q.port[p].pw != 3'h0) begin
        d.port[p].pw = q.port[p].pw - 3'h1;
        if (q.port[p].pw == 3'h1 && aux == `UBP_AUX_PLS) begin
          d.port[p].aux_on = 1'b0;
        end
      end
      if (sub == `UBP_SUB_IN) begin
        // A data read removes the oldest byte.
        if (rd_en && i_axi_araddr == (p == 0 ? `UBP_ADDR_DATA_A : `UBP_ADDR_DATA_B) &&
            q.port[p].cnt != 2'h0) begin
          d.port[p].fil = q.port[p].iil;
          d.port[p].cnt = q.port[p].cnt - 2'h1;
        end
        // Latch the byte on the strobe edge while a latch is free.
        take = q.en[p] && hs_edge[p] && q.port[p].cnt != 2'h2;
        if (take) begin
          if (d.port[p].cnt == 2'h0) begin
            d.port[p].fil = pin_in;
          end else begin
            d.port[p].iil = pin_in;
          end
          d.port[p].cnt = d.port[p].cnt + 2'h1;
        end
        // The strobe edge negates the handshake; it comes back when ready.
        if (hs_edge[p]) begin
          d.port[p].aux_on = 1'b0;
          d.port[p].owed = 1'b1;
          d.port[p].pw = 3'h0;
        end else if (hs && q.port[p].owed && q.en[p] && d.port[p].cnt != 2'h2) begin
          d.port[p].aux_on = 1'b1;
          d.port[p].owed = 1'b0;
          d.port[p].pw = `UBP_PULSE_CYC;
        end
        if (hs && aux == `UBP_AUX_ILK && d.port[p].cnt == 2'h2) begin
          d.port[p].aux_on = 1'b0;
        end
        // Output pins here are a single latch, written directly.
        if (wr_byte) begin
          d.port[p].olat = wr_data[7:0];
        end
      end else if (sub == `UBP_SUB_OUT) begin
        // An acknowledge only counts while a byte is held, and in the handshake codes only once it is presented.
        take = q.en[p] && hs_edge[p] && q.port[p].cnt != 2'h0 && (!hs || q.port[p].pres);
        if (take) begin
          d.port[p].aux_on = 1'b0;
          d.port[p].pres = 1'b0;
          d.port[p].pw = 3'h0;
          if (q.port[p].cnt == 2'h2) begin
            d.port[p].olat = q.port[p].iol;
            d.port[p].dly = `UBP_HS_DELAY_CYC;
          end
          d.port[p].cnt = q.port[p].cnt - 2'h1;
        end
        // Writes fill the double buffer whatever the pin directions; a
        // write to a full buffer is dropped.
        if (wr_byte && d.port[p].cnt != 2'h2) begin
          if (d.port[p].cnt == 2'h0) begin
            d.port[p].olat = wr_data[7:0];
            d.port[p].dly = `UBP_HS_DELAY_CYC;
          end else begin
            d.port[p].iol = wr_data[7:0];
          end
          d.port[p].cnt = d.port[p].cnt + 2'h1;
        end
        // A byte left over from a disabled spell is presented again.
        if (q.en[p] && q.port[p].owed) begin
          d.port[p].owed = 1'b0;
          d.port[p].dly = `UBP_HS_DELAY_CYC;
        end
      end else begin
        // Bit I/O is not handled here: writes just load the latch.
        if (wr_byte) begin
          d.port[p].olat = wr_data[7:0];
        end
      end
      // A disabled pair holds the handshake negated and forgets timers.
      if (!q.en[p]) begin
        d.port[p].aux_on = 1'b0;
        d.port[p].pres = 1'b0;
        d.port[p].pw = 3'h0;
        d.port[p].dly = 2'h0;
        d.port[p].owed = (sub == `UBP_SUB_IN) ? 1'b1 : (d.port[p].cnt != 2'h0);
      end
      // Second-pin status: the set wins over a write-one clear.
      if (wr_en && wr_strb[0] && wr_addr == `UBP_ADDR_STAT && wr_data[2*p+1]) begin
        d.port[p].aux_st = 1'b0;
      end
      if (aux[2] == 1'b0 && hs_edge[p+2]) begin
        d.port[p].aux_st = 1'b1;
      end
      if (aux[2] == 1'b1 || !q.en[p]) begin
        d.port[p].aux_st = 1'b0;
      end
      // First-pin status follows the buffer fill level.
      if (sub == `UBP_SUB_IN) begin
        d.port[p].strobe_st = d.port[p].cnt != 2'h0;
      end else if (sub == `UBP_SUB_OUT) begin
        if (d.port[p].ctrl[`UBP_STC_BIT]) begin
          d.port[p].strobe_st = d.port[p].cnt == 2'h0;
        end else begin
          d.port[p].strobe_st = d.port[p].cnt != 2'h2;
        end
      end else begin
        d.port[p].strobe_st = 1'b0;
      end
      // Requests gated by their enables.
      d.port[p].svc = d.port[p].strobe_st & d.port[p].ctrl[`UBP_SVCE_BIT];
      d.port[p].auxirq = d.port[p].aux_st & d.port[p].ctrl[`UBP_AUXIE_BIT];
      // Second-pin driver from the new control code.
      aux = d.port[p].ctrl[`UBP_AUX_HI:`UBP_AUX_LO];
      d.port[p].aux_oe = d.port[p].ctrl[`UBP_AUX_OUT_BIT];
      case (aux)
        `UBP_AUX_NEG: d.port[p].aux_pin = pin_lvl(1'b0);
        `UBP_AUX_ASR: d.port[p].aux_pin = pin_lvl(1'b1);
        `UBP_AUX_ILK: d.port[p].aux_pin = pin_lvl(d.port[p].aux_on);
        `UBP_AUX_PLS: d.port[p].aux_pin = pin_lvl(d.port[p].aux_on);
        default: d.port[p].aux_pin = pin_lvl(1'b0);
      endcase
    end
  end

  // ========================================================================
  // State register. Reset clears every control bit, so both ports come up
  // in submode 00 with the second pins as inputs.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
      q.port[0].ctrl <= `UBP_CTRL_RST;
      q.port[1].ctrl <= `UBP_CTRL_RST;
      q.port[0].owed <= 1'b1;
      q.port[1].owed <= 1'b1;
      q.port[0].strobe_st <= 1'b0;
      q.port[1].strobe_st <= 1'b0;
      q.port[0].aux_pin <= ~`UBP_ACT_HIGH;
      q.port[1].aux_pin <= ~`UBP_ACT_HIGH;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Pin outputs, all taken from registered state. The output latch drives
  // a pin only where its direction bit is one.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      o_port_data[8*p +: 8] = q.port[p].olat;
      o_port_data_oe[8*p +: 8] = q.port[p].ddr;
      o_handshake_aux[p] = q.port[p].aux_pin;
      o_handshake_aux_oe[p] = q.port[p].aux_oe;
      o_service_request[p] = q.port[p].svc;
      o_aux_irq[p] = q.port[p].auxirq;
    end
  end
endmodule

/* File: testbench/ubp_monitor.sv */
/* Port checker of the byte port block.
   Assumes it is bound to ubp_top, and that port A meets no strobe and no data write
   while its second pin is held high by code 101 or by an input handshake. */
module ubp_monitor (
  // Bus and pins of ubp_top.
  input wire logic i_clk, i_nrst, i_axi_awvalid, o_axi_awready, i_axi_wvalid, o_axi_wready,
  input wire logic o_axi_bvalid, i_axi_bready, i_axi_arvalid, o_axi_arready, o_axi_rvalid,
  input wire logic i_axi_rready,
  input wire logic [1:0] o_axi_bresp, i_strobe_in, o_handshake_aux, o_handshake_aux_oe,
  input wire logic [31:0] o_axi_rdata,
  input wire logic [15:0] o_port_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // One clock, so one default clocking.
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_wr;
    i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready && !o_axi_bvalid;
  endsequence
  sequence s_ack;
    $rose(i_strobe_in[0]) && o_handshake_aux[0] && o_handshake_aux_oe[0];
  endsequence
  a_wr_answer: assert property (s_wr |-> ##[1:3] o_axi_bvalid) else $error("no write answer");
  a_b_holds: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("write answer moved");
  a_b_code: assert property (o_axi_bvalid |-> o_axi_bresp inside {2'h0, 2'h3}) else $error("bad code");
  a_rd_answer: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid) else $error("no read");
  a_r_holds: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
    else $error("read data moved");
  a_ar_blocked: assert property (o_axi_rvalid |-> !o_axi_arready) else $error("read overlap");
  a_r_once: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid) else $error("read answered twice");
  a_ack_drops: assert property (s_ack |=> !o_handshake_aux[0])
    else $error("handshake kept");
  a_data_holds: assert property (o_handshake_aux_oe[0] && o_handshake_aux[0]
    && $past(o_handshake_aux[0]) |-> $stable(o_port_data[7:0])) else $error("data moved");
endmodule
bind ubp_top ubp_monitor i_ubp_monitor (.i_clk, .i_nrst, .i_axi_awvalid, .o_axi_awready, .i_axi_wvalid,
  .o_axi_wready, .o_axi_bvalid, .i_axi_bready, .i_axi_arvalid, .o_axi_arready, .o_axi_rvalid,
  .i_axi_rready, .o_axi_bresp, .i_strobe_in, .o_handshake_aux, .o_handshake_aux_oe, .o_axi_rdata,
  .o_port_data);

/* File: testbench/ubp_periph.sv */
/* Peripheral model at the pins of the byte port block.
   Assumes the testbench calls its tasks one at a time. */
module ubp_periph (
  // Clock.
  input wire logic i_clk,
  // Pins towards the device.
  output logic [1:0] o_strobe,
  output logic [15:0] o_data,
  output logic [1:0] o_aux
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_strobe = 2'h0;
    o_data = 16'h0;
    o_aux = 2'h0;
  end
  // Byte held one cycle past the strobe edge, then inverted so stale data never looks valid.
  task present(input int p, input logic [7:0] b);
    @(posedge i_clk);
    o_data[p*8+:8] <= b;
    o_strobe[p] <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_strobe[p] <= 1'b0;
    o_data[p*8+:8] <= ~b;
  endtask
  // One asserted edge on the second pin.
  task aux_edge(input int p);
    @(posedge i_clk);
    o_aux[p] <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_aux[p] <= 1'b0;
  endtask
endmodule

/* File: testbench/testbench.sv */
/* Self-checking bench of the byte port block.
   Assumes ubp_top, ubp_periph and the checker are compiled first. */
`include "ubp_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Bus and pin signals; the aux wire mixes both parties by enable.
  logic i_clk, i_nrst, awv, wv, bry, arv, rry, aw_r, w_r, bv, ar_r, rv, ta, tw, tb;
  logic [3:0] wst;
  logic [7:0] awa, ara;
  logic [31:0] wda, rda, rdg;
  logic [1:0] rrs, rrg, brs, brg, aux, oe, p_aux, stb, svc, irq;
  logic [15:0] p_data, d_out, d_oe;
  wire logic [1:0] aux_w = (oe & aux) | (~oe & p_aux);
  int failures = 0, checks = 0, cyc = 0, w, n;
  ubp_top i_ubp_top (.i_clk, .i_nrst, .i_axi_awvalid(awv), .o_axi_awready(aw_r), .i_axi_awaddr(awa),
    .i_axi_wvalid(wv), .o_axi_wready(w_r), .i_axi_wdata(wda), .i_axi_wstrb(wst), .o_axi_bvalid(bv),
    .i_axi_bready(bry), .o_axi_bresp(brs), .i_axi_arvalid(arv), .o_axi_arready(ar_r), .i_axi_araddr(ara),
    .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rda), .o_axi_rresp(rrs), .i_port_data(p_data),
    .o_port_data(d_out), .o_port_data_oe(d_oe), .i_strobe_in(stb), .i_handshake_aux(aux_w),
    .o_handshake_aux(aux), .o_handshake_aux_oe(oe), .o_service_request(svc), .o_aux_irq(irq));
  ubp_periph i_ubp_periph (.i_clk, .o_strobe(stb), .o_data(p_data), .o_aux(p_aux));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // A hang counts as a failure.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  // ========
  // Shared tasks; readies are looked at mid-cycle, so no edge race.
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {awv, wv, bry, awa, wda} <= {3'h7, a, d};
    do begin
      @(negedge i_clk);
      {ta, tw, tb, brg} = {aw_r, w_r, bv, brs};
      @(posedge i_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bry <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    {arv, rry, ara} <= {2'h3, a};
    do begin
      @(negedge i_clk);
      {ta, tb, rdg, rrg} = {ar_r, rv, rda, rrs};
      @(posedge i_clk);
      if (ta) arv <= 1'b0;
    end while (!tb);
    rry <= 1'b0;
    chk(rdg, e);
    chk(rrg, er);
  endtask
  // Cycles until the second pin rises (w), then how long it stays, capped at 8 (n).
  task hi_len(input int p);
    w = 0;
    n = 0;
    do begin @(negedge i_clk); w++; end while (aux[p] !== 1'b1 && w < 20);
    while (aux[p] === 1'b1 && n < 8) begin @(negedge i_clk); n++; end
  endtask
  // ========
  // Scenarios.
  task t_out;
    rdc(`UBP_ADDR_CTRL_A, 32'h0, 2'h0);
    rdc(8'h40, 32'h0, 2'h3);
    axw(8'h40, 32'h0);
    chk(brg, 2'h3);
    axw(`UBP_ADDR_CTRL_A, 32'h70);
    chk(brg, 2'h0);
    axw(`UBP_ADDR_DDR_A, 32'h0f);
    axw(`UBP_ADDR_GEN, 32'h1);
    rdc(`UBP_ADDR_STAT, 32'h1, 2'h0);
    axw(`UBP_ADDR_DATA_A, 32'h3c);
    hi_len(0);
    chk(w, 2);
    chk(n, 8);
    chk({d_oe, d_out}, 32'h000f003c);
    axw(`UBP_ADDR_DATA_A, 32'hc3);
    rdc(`UBP_ADDR_STAT, 32'h0, 2'h0);
    i_ubp_periph.present(0, 8'h0);
    hi_len(0);
    chk(w, 2);
    chk({16'h0, d_out}, 32'hc3);
    axw(`UBP_ADDR_CTRL_A, 32'h71);
    rdc(`UBP_ADDR_STAT, 32'h0, 2'h0);
    i_ubp_periph.present(0, 8'h0);
    rdc(`UBP_ADDR_STAT, 32'h1, 2'h0);
    axw(`UBP_ADDR_CTRL_A, 32'h78);
    axw(`UBP_ADDR_DATA_A, 32'h55);
    hi_len(0);
    chk(n, 4);
    $display("output test done");
  endtask
  task t_in;
    axw(`UBP_ADDR_CTRL_B, 32'h32);
    axw(`UBP_ADDR_GEN, 32'h3);
    hi_len(1);
    chk(n, 8);
    i_ubp_periph.present(1, 8'h5a);
    i_ubp_periph.present(1, 8'ha5);
    @(negedge i_clk);
    chk({aux[1], svc[1]}, 2'h1);
    rdc(`UBP_ADDR_STAT, 32'h5, 2'h0);
    rdc(`UBP_ADDR_DATA_B, 32'h5a, 2'h0);
    rdc(`UBP_ADDR_DATA_B, 32'ha5, 2'h0);
    rdc(`UBP_ADDR_STAT, 32'h1, 2'h0);
    $display("input test done");
  endtask
  task t_aux;
    axw(`UBP_ADDR_CTRL_A, 32'h44);
    i_ubp_periph.aux_edge(0);
    @(negedge i_clk);
    chk(irq, 2'h1);
    rdc(`UBP_ADDR_STAT, 32'h3, 2'h0);
    axw(`UBP_ADDR_STAT, 32'h2);
    rdc(`UBP_ADDR_STAT, 32'h1, 2'h0);
    axw(`UBP_ADDR_CTRL_A, 32'h60);
    @(negedge i_clk);
    chk({aux[0], oe[0]}, 2'h1);
    axw(`UBP_ADDR_CTRL_A, 32'h68);
    @(negedge i_clk);
    chk({aux[0], oe[0]}, 2'h3);
    rdc(`UBP_ADDR_STAT, 32'h1, 2'h0);
    $display("aux test done");
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_nrst = 1'b0;
    {awv, wv, bry, arv, rry, awa, ara, wda, wst} = {5'h0, 48'h0, 4'hf};
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_out;
    t_in;
    t_aux;
    report_and_stop;
  end
endmodule
